// File: src/cfgseq_fifo.sv
`timescale 1ns/1ps
module cfgseq_fifo
	import cfgseq_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
)
(
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_reg[rd_ptr_reg];

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data_i;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule

// File: src/cfgseq_host.sv
`timescale 1ns/1ps
`include "cfgseq_map.svh"
module cfgseq_host
	import cfgseq_pkg::*;
#(
	parameter int DEPTH     = 32,
	parameter int USER_CYC  = `CFGSEQ_USER_CYC,
	parameter int SLACK_CYC = 64
)
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	output logic             config_reset_n_o,
	input  wire logic        config_done_flag_i,
	output logic             config_serial_clock_o,
	output logic      [7:0]  config_data_o,
	output logic             quarter_rate_clock_setting_o,
	output logic             user_reset_n_o
);
	// ********************************
	// constants and state
	// ********************************
	localparam int RST_CYC  = `CFGSEQ_RESET_CYC;
	localparam int DMIN_CYC = `CFGSEQ_DMIN_CYC;
	localparam int HALF_CYC = `CFGSEQ_HALF_CYC;

	cfgseq_state_t state_reg;
	cfgseq_state_t state_next;
	logic [31:0]   timer_reg;
	logic [31:0]   limit_reg;
	logic [2:0]    done_sync_reg;
	logic          passive_reg;
	logic          jtag_up_reg;
	logic [1:0]    lanes_reg;
	logic          chain_reg;
	logic          quarter_reg;
	logic          timeout_reg;
	logic          bad_div_reg;
	logic [1:0]    half_reg;
	logic          sck_reg;
	logic [7:0]    shift_reg;
	logic [3:0]    bits_left_reg;
	logic          have_byte_reg;
	logic          ack_reg;
	logic          fifo_in_valid;
	logic          fifo_in_ready;
	logic          fifo_out_valid;
	logic          fifo_out_ready;
	logic [7:0]    fifo_out_data;
	logic          done_level;
	logic          done_rise;
	logic          start_cmd;
	logic          access;
	logic          timer_hit;

	// lane count decoding, used by shifting and by the chain limit
	function automatic logic [3:0] lane_count(input logic [1:0] code);
		case (code)
			2'b00:   lane_count = 4'h1;
			2'b01:   lane_count = 4'h2;
			2'b10:   lane_count = 4'h4;
			default: lane_count = 4'h8;
		endcase
	endfunction

	// ********************************
	// avalon slave, single wait cycle unless a data write finds the fifo full
	// ********************************
	assign access            = avs_read_i || avs_write_i;
	assign avs_waitrequest_o = access && !ack_reg;
	assign start_cmd = avs_write_i && ack_reg
		&& avs_address_i == `CFGSEQ_OFS_CTRL
		&& avs_writedata_i[`CFGSEQ_CTRL_START];
	assign fifo_in_valid = avs_write_i && ack_reg
		&& avs_address_i == `CFGSEQ_OFS_DATA;

	// data writes stall while the buffer is full, so back-pressure
	// reaches software rather than dropping bytes
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			ack_reg <= 1'b0;
		else if (ack_reg)
			ack_reg <= 1'b0;
		else if (avs_read_i)
			ack_reg <= 1'b1;
		else if (avs_write_i)
			ack_reg <= (avs_address_i != `CFGSEQ_OFS_DATA) || fifo_in_ready;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			avs_readdata_o <= 32'h0000_0000;
		else if (avs_read_i && !ack_reg)
		begin
			case (avs_address_i)
				`CFGSEQ_OFS_CTRL:
					avs_readdata_o <= {29'h0, jtag_up_reg, passive_reg, 1'b0};
				`CFGSEQ_OFS_STATUS:
					avs_readdata_o <= {26'h0, bad_div_reg, !fifo_in_ready,
						timeout_reg, state_reg == CFGSEQ_USER, done_level,
						state_reg != CFGSEQ_IDLE && state_reg != CFGSEQ_USER};
				`CFGSEQ_OFS_CONFIG:
					avs_readdata_o <= {28'h0, quarter_reg, chain_reg,
						lanes_reg};
				default:
					avs_readdata_o <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			passive_reg <= 1'b0;
			jtag_up_reg <= 1'b0;
			lanes_reg   <= 2'b00;
			chain_reg   <= 1'b0;
			quarter_reg <= 1'b1;
		end
		else if (avs_write_i && ack_reg)
		begin
			if (avs_address_i == `CFGSEQ_OFS_CTRL)
			begin
				passive_reg <= avs_writedata_i[`CFGSEQ_CTRL_PASSIVE];
				jtag_up_reg <= avs_writedata_i[`CFGSEQ_CTRL_JTAG_UP];
			end
			else if (avs_address_i == `CFGSEQ_OFS_CONFIG)
			begin
				lanes_reg <= avs_writedata_i[`CFGSEQ_CFG_LANES_HI:
					`CFGSEQ_CFG_LANES_LO];
				chain_reg   <= avs_writedata_i[`CFGSEQ_CFG_CHAIN];
				quarter_reg <= avs_writedata_i[`CFGSEQ_CFG_QUARTER];
			end
		end
	end

	// chains of two or four lanes need the quarter-rate setting
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			bad_div_reg <= 1'b0;
		else
			bad_div_reg <= !quarter_reg
				&& (lanes_reg == 2'b01 || lanes_reg == 2'b10);
	end
	assign quarter_rate_clock_setting_o = quarter_reg;

	// ********************************
	// done flag synchroniser
	// ********************************
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			done_sync_reg <= 3'b000;
		else
			done_sync_reg <= {done_sync_reg[1:0], config_done_flag_i};
	end
	assign done_level = done_sync_reg[1];
	assign done_rise  = done_sync_reg[1] && !done_sync_reg[2];

	// ********************************
	// sequencer
	// ********************************
	assign timer_hit = (timer_reg + 32'h1 >= limit_reg);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			CFGSEQ_IDLE:
				if (start_cmd)
					state_next = CFGSEQ_RESET;
			CFGSEQ_RESET:
				if (timer_hit)
					state_next = passive_reg ? CFGSEQ_DMIN : CFGSEQ_DONE;
			CFGSEQ_DMIN:
				if (timer_hit)
					state_next = CFGSEQ_LOAD;
			CFGSEQ_LOAD:
				if (done_level)
					state_next = CFGSEQ_WAIT;
			CFGSEQ_DONE:
				if (done_rise || (done_level && jtag_up_reg))
					state_next = CFGSEQ_WAIT;
			CFGSEQ_WAIT:
				if (timer_hit)
					state_next = CFGSEQ_USER;
			CFGSEQ_USER:
				if (start_cmd)
					state_next = CFGSEQ_RESET;
			default:
				state_next = CFGSEQ_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			state_reg <= CFGSEQ_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			timer_reg <= 32'h0000_0000;
			limit_reg <= 32'h0000_0001;
		end
		else if (state_next != state_reg)
		begin
			timer_reg <= 32'h0000_0000;
			case (state_next)
				CFGSEQ_RESET:
					limit_reg <= 32'(RST_CYC);
				CFGSEQ_DMIN:
					limit_reg <= 32'(DMIN_CYC);
				default:
					limit_reg <= 32'(USER_CYC);
			endcase
		end
		else
			timer_reg <= timer_reg + 32'h1;
	end

	// chain master bound: 1344/lanes clock periods past the minimum wait
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			timeout_reg <= 1'b0;
		else if (state_reg == CFGSEQ_DONE && timer_reg > 32'(USER_CYC
			+ SLACK_CYC) + (chain_reg ? 32'(`CFGSEQ_CHAIN_BITS
			/ lane_count(lanes_reg)) * 32'(2 * HALF_CYC) : 32'h0))
			timeout_reg <= 1'b1;
		else if (start_cmd)
			timeout_reg <= 1'b0;
	end

	// ********************************
	// pins
	// ********************************
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			config_reset_n_o <= 1'b1;
			user_reset_n_o   <= 1'b0;
		end
		else
		begin
			config_reset_n_o <= (state_next != CFGSEQ_RESET);
			user_reset_n_o   <= (state_next == CFGSEQ_USER);
		end
	end

	// ********************************
	// passive loader
	// ********************************
	// 50 percent duty at 12.5 MHz within a byte, low phase one cycle longer between bytes, meets the 25 MHz ceiling with room
	assign fifo_out_ready = (state_reg == CFGSEQ_LOAD) && !have_byte_reg;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			half_reg      <= 2'b00;
			sck_reg       <= 1'b0;
			shift_reg     <= 8'h00;
			bits_left_reg <= 4'h0;
			have_byte_reg <= 1'b0;
			config_data_o <= 8'h00;
		end
		else if (state_reg != CFGSEQ_LOAD)
		begin
			half_reg      <= 2'b00;
			sck_reg       <= 1'b0;
			have_byte_reg <= 1'b0;
		end
		else if (fifo_out_valid && fifo_out_ready)
		begin
			shift_reg     <= fifo_out_data;
			bits_left_reg <= 4'h8;
			have_byte_reg <= 1'b1;
			// lanes settle a whole low phase before the rising edge
			config_data_o <= fifo_out_data;
		end
		else if (have_byte_reg)
		begin
			if (half_reg == 2'(HALF_CYC - 1))
			begin
				half_reg <= 2'b00;
				sck_reg  <= !sck_reg;
				if (!sck_reg)
				begin
					shift_reg     <= shift_reg << lane_count(lanes_reg);
					bits_left_reg <= bits_left_reg - lane_count(lanes_reg);
				end
				else if (bits_left_reg == 4'h0)
					have_byte_reg <= 1'b0;
				else
					config_data_o <= shift_reg;
			end
			else
				half_reg <= half_reg + 2'b01;
		end
	end
	assign config_serial_clock_o = sck_reg;

	cfgseq_fifo #(
		.WIDTH(8),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_i      (clk_i),
		.reset_n_i  (reset_n_i),
		.in_valid_i (fifo_in_valid),
		.in_ready_o (fifo_in_ready),
		.in_data_i  (avs_writedata_i[7:0]),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o (fifo_out_data)
	);
endmodule

// File: src/cfgseq_map.svh
`ifndef CFGSEQ_MAP_SVH
`define CFGSEQ_MAP_SVH

// avalon register offsets (word aligned, on a 4-bit byte address)
`define CFGSEQ_OFS_CTRL      4'h0
`define CFGSEQ_OFS_STATUS    4'h4
`define CFGSEQ_OFS_DATA      4'h8
`define CFGSEQ_OFS_CONFIG    4'hC

// control fields
`define CFGSEQ_CTRL_START    0
`define CFGSEQ_CTRL_PASSIVE  1
`define CFGSEQ_CTRL_JTAG_UP  2

// config fields
`define CFGSEQ_CFG_LANES_LO  0
`define CFGSEQ_CFG_LANES_HI  1
`define CFGSEQ_CFG_CHAIN     2
`define CFGSEQ_CFG_QUARTER   3

// status fields
`define CFGSEQ_ST_BUSY       0
`define CFGSEQ_ST_DONE       1
`define CFGSEQ_ST_USER       2
`define CFGSEQ_ST_TIMEOUT    3
`define CFGSEQ_ST_FIFO_FULL  4
`define CFGSEQ_ST_BAD_DIV    5

// timing, in their own units, and clock rate
`define CFGSEQ_CLK_MHZ       50
`define CFGSEQ_T_RESET_NS    320
`define CFGSEQ_T_USER_US     12
`define CFGSEQ_T_DMIN_NS     1200
`define CFGSEQ_CHAIN_BITS    1344

// least times round up to whole cycles
`define CFGSEQ_RESET_CYC \
	((`CFGSEQ_T_RESET_NS * `CFGSEQ_CLK_MHZ + 999) / 1000)
`define CFGSEQ_USER_CYC      (`CFGSEQ_T_USER_US * `CFGSEQ_CLK_MHZ)
`define CFGSEQ_DMIN_CYC \
	((`CFGSEQ_T_DMIN_NS * `CFGSEQ_CLK_MHZ + 999) / 1000)

// passive clock half period in system cycles; 50 MHz / 4 = 12.5 MHz
`define CFGSEQ_HALF_CYC      2

`endif

// File: src/cfgseq_pkg.sv
package cfgseq_pkg;

	typedef enum logic [2:0]
	{
		CFGSEQ_IDLE  = 3'b000,
		CFGSEQ_RESET = 3'b001,
		CFGSEQ_DMIN  = 3'b010,
		CFGSEQ_LOAD  = 3'b011,
		CFGSEQ_DONE  = 3'b100,
		CFGSEQ_WAIT  = 3'b101,
		CFGSEQ_USER  = 3'b110
	} cfgseq_state_t;

endpackage

// File: verif/cfgseq_dev_model.sv
`timescale 1ns/1ps
module cfgseq_dev_model
#(
	parameter int BYTES = 32
)
(
	input wire logic       rst_n_i,
	input wire logic       sck_i,
	input wire logic [7:0] data_i,
	input wire logic       passive_i,
	input wire logic       quarter_i,
	input wire logic       hang_i,
	output logic           done_o,
	output logic           err_o,
	output logic     [7:0] first_o
);
	realtime t_fall;
	realtime t_rise;
	realtime t_edge;
	realtime t_per;
	int      n;
	initial
	begin
		done_o = 1'b0;
		err_o = 1'b0;
		first_o = 8'h00;
		n = 0;
		t_fall = -1.0;
		t_per = -100.0;
		t_edge = -100.0;
	end
	always @(negedge rst_n_i)
	begin
		t_fall = $realtime;
		done_o = 1'b0;
		n = 0;
	end
	always @(posedge rst_n_i)
	begin
		t_rise = $realtime;
		if (t_fall >= 0.0 && t_rise - t_fall < 320.0)
			err_o = 1'b1;
		// active image of 16 clocks at 20 or 10 MHz
		if (t_fall >= 0.0 && !passive_i && !hang_i)
		begin
			#((quarter_i ? 50.0 : 100.0) * 16);
			done_o = 1'b1;
		end
	end
	always @(posedge sck_i)
		if (rst_n_i && !done_o)
		begin
			if ($realtime - t_rise < 1200.0)
				err_o = 1'b1;
			if ($realtime - t_per < 40.0)
				err_o = 1'b1;
			if ($realtime - t_edge < 19.2)
				err_o = 1'b1;
			t_per = $realtime;
			t_edge = $realtime;
			if (n == 0)
				first_o = data_i;
			n++;
			if (n == BYTES)
				done_o = 1'b1;
		end
	always @(negedge sck_i)
	begin
		if ($realtime - t_edge < 19.2)
			err_o = 1'b1;
		t_edge = $realtime;
	end
endmodule

// File: verif/cfgseq_host_sva.sv
`timescale 1ns/1ps
module cfgseq_host_sva
#(
	parameter int USER_CYC = 20
)
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic avs_read_i,
	input wire logic avs_waitrequest_o,
	input wire logic config_reset_n_o,
	input wire logic config_done_flag_i,
	input wire logic config_serial_clock_o,
	input wire logic user_reset_n_o
);
	// 1.2 us at 50 MHz
	localparam int DMIN_CYC = 60;
	logic [10:0] done_cnt;
	logic [10:0] rel_cnt;
	// counters saturate so a long idle never wraps back below the limits
	always_ff @(posedge clk_i or negedge reset_n_i)
		if (!reset_n_i)
			done_cnt <= 11'h000;
		else if (!config_done_flag_i)
			done_cnt <= 11'h000;
		else if (done_cnt != 11'h7FF)
			done_cnt <= done_cnt + 11'h001;
	always_ff @(posedge clk_i or negedge reset_n_i)
		if (!reset_n_i)
			rel_cnt <= 11'h000;
		else if (!config_reset_n_o)
			rel_cnt <= 11'h000;
		else if (rel_cnt != 11'h7FF)
			rel_cnt <= rel_cnt + 11'h001;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_low8;
		(!config_reset_n_o)[*8];
	endsequence
	a_reset_len:
	assert property ($fell(config_reset_n_o) |-> s_low8 ##1 s_low8)
		else $error("reconfig reset pulse too short");
	a_user_wait:
	assert property ($rose(user_reset_n_o) |-> done_cnt >= USER_CYC)
		else $error("user reset released early");
	a_user_held:
	assert property ((!config_reset_n_o)[*2] |-> !user_reset_n_o)
		else $error("user side out of reset during reconfig");
	a_first_data:
	assert property ($rose(config_serial_clock_o) |-> rel_cnt >= DMIN_CYC)
		else $error("passive clock starts too soon");
	a_sck_high:
	assert property ($rose(config_serial_clock_o) |=>
		config_serial_clock_o || config_done_flag_i)
		else $error("passive clock high phase short");
	a_sck_low:
	assert property ($fell(config_serial_clock_o) && !config_done_flag_i
		|=> !config_serial_clock_o)
		else $error("passive clock low phase short");
	a_sck_idle:
	assert property (!config_reset_n_o |-> !config_serial_clock_o)
		else $error("passive clock runs in reset");
	a_read_ack:
	assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1
		!avs_waitrequest_o)
		else $error("read answer late");
endmodule
bind cfgseq_host cfgseq_host_sva #(.USER_CYC(USER_CYC)) cfgseq_host_sva_i (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_read_i(avs_read_i),
	.avs_waitrequest_o(avs_waitrequest_o),
	.config_reset_n_o(config_reset_n_o),
	.config_done_flag_i(config_done_flag_i),
	.config_serial_clock_o(config_serial_clock_o),
	.user_reset_n_o(user_reset_n_o));

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic        clk;
	logic        rst_n;
	logic [3:0]  adr;
	logic        rd;
	logic        wr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        wreq;
	logic        crst_n;
	logic        done;
	logic        sck;
	logic [7:0]  cdat;
	logic        qrt;
	logic        urst_n;
	logic        psv;
	logic        hang;
	logic        err;
	logic [7:0]  first;
	logic [31:0] q;
	int          miscompares;
	int          compares;
	int          cyc;
	cfgseq_host #(.USER_CYC(20)) cfgseq_host_i (.clk_i(clk),
		.reset_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .config_reset_n_o(crst_n),
		.config_done_flag_i(done), .config_serial_clock_o(sck),
		.config_data_o(cdat), .quarter_rate_clock_setting_o(qrt),
		.user_reset_n_o(urst_n));
	cfgseq_dev_model cfgseq_dev_model_i (.rst_n_i(crst_n), .sck_i(sck),
		.data_i(cdat), .passive_i(psv), .quarter_i(qrt), .hang_i(hang),
		.done_o(done), .err_o(err), .first_o(first));
	task end_of_test;
		$display("checks %0d mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	// request held until the rising edge that samples waitrequest low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		do
			@(posedge clk);
		while (wreq !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task rchk(input string nm, input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, q & m);
	endtask
	task wait_user;
		int n;
		n = 0;
		while (urst_n !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		cyc = 0;
		forever
		begin
			@(posedge clk);
			cyc++;
			if (cyc > 20000)
			begin
				miscompares++;
				end_of_test;
			end
		end
	end
	initial
	begin
		rst_n = 1'b0;
		adr = 4'h0;
		rd = 1'b0;
		wr = 1'b0;
		wdat = 32'h0;
		psv = 1'b0;
		hang = 1'b0;
		miscompares = 0;
		compares = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		// ************
		// reset values
		// ************
		rchk("ctrl", 4'h0, 32'hFFFFFFFF, 32'h0);
		rchk("status", 4'h4, 32'hFFFFFFFF, 32'h0);
		rchk("config", 4'hC, 32'hFFFFFFFF, 32'h8);
		rchk("unmapped", 4'h2, 32'hFFFFFFFF, 32'h0);
		chk("quarter", 32'h1, {31'h0, qrt});
		chk("user_rst", 32'h0, {31'h0, urst_n});
		$display("test reset done");
		// ******************************
		// divider check on narrow chains
		// ******************************
		bus(1'b1, 4'hC, 32'h1);
		rchk("bad_div", 4'h4, 32'h20, 32'h20);
		chk("quarter_off", 32'h0, {31'h0, qrt});
		bus(1'b1, 4'hC, 32'hB);
		rchk("div_ok", 4'h4, 32'h20, 32'h0);
		$display("test divider done");
		// *****************************************
		// passive load of a full fifo, eight lanes
		// *****************************************
		psv = 1'b1;
		for (int i = 0; i < 32; i++)
			bus(1'b1, 4'h8, 32'hA5 + i);
		rchk("fifo_full", 4'h4, 32'h10, 32'h10);
		bus(1'b1, 4'h0, 32'h3);
		wait_user;
		chk("dev_err", 32'h0, {31'h0, err});
		chk("first_byte", 32'hA5, {24'h0, first});
		rchk("passive_st", 4'h4, 32'h1E, 32'h6);
		$display("test passive done");
		// ***********************************
		// active load, device clocks itself
		// ***********************************
		psv = 1'b0;
		bus(1'b1, 4'h0, 32'h1);
		@(negedge clk);
		chk("user_held", 32'h0, {31'h0, urst_n});
		wait_user;
		chk("active_err", 32'h0, {31'h0, err});
		rchk("active_st", 4'h4, 32'h0E, 32'h6);
		$display("test active done");
		// ******************************
		// jtag load, enter-user reported
		// ******************************
		bus(1'b1, 4'h0, 32'h5);
		rchk("jtag_ctrl", 4'h0, 32'hFFFFFFFF, 32'h4);
		wait_user;
		rchk("jtag_st", 4'h4, 32'h0E, 32'h6);
		$display("test jtag done");
		// *************************************
		// device never finishes, wait times out
		// *************************************
		hang = 1'b1;
		bus(1'b1, 4'h0, 32'h1);
		q = 32'h0;
		for (int i = 0; i < 100 && q[3] !== 1'b1; i++)
			bus(1'b0, 4'h4, 32'h0);
		chk("timeout", 32'h8, q & 32'h0C);
		$display("test timeout done");
		end_of_test;
	end
endmodule
